// *** common/ucc_pkg.sv ***
// Purpose: Shared constants and carriers for the control character and urgent transmit block
// Assumes: 16-bit register port, byte offsets as listed
// Notes: Offsets at and above 0x14 hold block-local control and status
package ucc_pkg;
   localparam logic [5:0] ADDR_ENTRY_BASE = 6'h00;
   localparam logic [5:0] ADDR_MASK = 6'h10;
   localparam logic [5:0] ADDR_REJ = 6'h12;
   localparam logic [5:0] ADDR_URGENT = 6'h14;
   localparam logic [5:0] ADDR_CTRL = 6'h16;
   localparam logic [5:0] ADDR_BRKCNT = 6'h18;
   localparam logic [5:0] ADDR_STATUS = 6'h1a;
   localparam int NUM_ENTRIES = 8;
   localparam int BIT_END = 15;
   localparam int BIT_REJECT = 14;
   localparam int BIT_READY = 13;
   localparam int BIT_IRQ = 12;
   localparam int BIT_LOST_CTS = 11;
   localparam int BIT_ADDR = 8;
   localparam logic [15:0] ENTRY_RESET = 16'h8000;
   localparam logic [15:0] MASK_RESET = 16'hc0ff;
   // Software may set ready, interrupt, address and character; bits 15-14 and 10-9 read zero
   localparam logic [15:0] URGENT_WMASK = 16'h31ff;
   // Control register bits
   localparam int CTL_TX_EN = 0;
   localparam int CTL_WAKE_ADDR = 1;
   localparam int CTL_HUNT = 2;
   localparam int CTL_CTS_MON = 3;
   localparam int CTL_BRK_IE = 4;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   // Idle for one character time, in bit enables
   localparam logic [3:0] IDLE_BITS = 4'ha;

   typedef struct packed {
      logic [7:0] data;
      logic addr_bit;
      logic break_event;
   } ucc_rx_char_t;

   typedef struct packed {
      logic [7:0] data;
      logic addr_bit;
   } ucc_tx_char_t;

   typedef enum logic [1:0] {
      UCC_TX_IDLE = 2'b00,
      UCC_TX_WAIT = 2'b01,
      UCC_TX_SEND = 2'b10
   } ucc_tx_state_t;
endpackage

// *** hdl/ucc_ctrl_char_oos.sv ***
// Purpose: Control character recognition, hunt/sleep and urgent character insertion
// Assumes: Framing, FIFO and serializer live in the channel; this block steers them
// Notes: All inputs are on i_ref_clk except i_cts_n which is synchronised
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Function
// (RQ1) Up to eight control characters compared against each received character.
// (RQ2) Entry: bit 15 end flag, bit 14 reject, low byte character.
// (RQ3) End flag zero means valid; first set flag stops the scan.
// (RQ4) Accepted match stores character, closes buffer, raises descriptor-maskable event.
// (RQ5) Rejected match is not stored; goes to holding register with event.
// (RQ6) Mask zero bits skip comparison; one bits compare normally.
// (RQ7) Software keeps mask bits 15 and 14 set.
// (RQ8) Software zeroes unused upper bits of short characters.
// (RQ9) Holding register is overwritten by each new rejected character.
// (RQ10) Hunt keeps receiver asleep until idle character time or address bit.
// (RQ11) Break while asleep bumps break counter and raises enabled break event.
// (RQ12) Urgent entry polled whenever transmitter enabled, buffer or not.
// (RQ13) Urgent character goes ahead of buffer data, after FIFO contents.
// (RQ14) Software should shorten the FIFO to one before enabling.
// (RQ15) Urgent entry: 15-14 ignored, ready 13, lost CTS 11, address 8.
// (RQ16) Ready stays set during sending and is cleared by the device after.
// (RQ17) With its interrupt flag set, sending sets the transmit event.
// (RQ18) Lost CTS flag and event set when monitored CTS negates during send.
// (RQ19) Software changes the character only while ready is clear.
// (RQ20) Software places the multidrop address bit in bit 8.
// (RQ21) Urgent character uses the channel's normal framing.
module ucc_ctrl_char_oos (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [5:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic i_rx_valid,
   input wire ucc_pkg::ucc_rx_char_t i_rx_char,
   input wire logic i_bit_en,
   input wire logic i_line_idle,
   output logic o_rx_store,
   output logic o_rx_close,
   output logic o_rx_drop,
   output logic o_evt_ctrl_accept,
   output logic o_evt_ctrl_reject,
   output logic o_evt_break,
   output logic o_evt_tx,
   output logic o_evt_cts,
   output logic o_rx_asleep,
   output logic o_tx_enable,
   input wire logic i_fifo_ready,
   output logic o_urgent_valid,
   output ucc_pkg::ucc_tx_char_t o_urgent_char,
   output logic o_hold_buffer,
   input wire logic i_char_sent,
   input wire logic i_cts_n
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [15:0] entry_ff [ucc_pkg::NUM_ENTRIES];
   logic [15:0] mask_ff;
   logic [15:0] rej_ff;
   logic [15:0] urgent_ff;
   logic [15:0] ctl_ff;
   logic [15:0] brk_cnt_ff;
   logic [15:0] rdata_ff;
   logic asleep_ff;
   logic [3:0] idle_cnt_ff;
   ucc_pkg::ucc_tx_state_t state_ff;
   ucc_pkg::ucc_tx_state_t nxt_state;
   logic cts_meta_ff;
   logic cts_sync_ff;
   logic cts_lost_ff;
   logic store_ff, close_ff, drop_ff, acc_ff, rej_evt_ff, brk_evt_ff, tx_evt_ff, cts_evt_ff;

   function automatic logic char_match(input logic [15:0] ent, input logic [7:0] ch, input logic [7:0] msk);
      char_match = ((ent[7:0] ^ ch) & msk) == 8'h00;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire wr_entry = i_wr && (i_addr < ucc_pkg::ADDR_MASK) && !i_addr[0];
   wire [2:0] entry_idx = i_addr[3:1];
   wire wr_mask = i_wr && (i_addr == ucc_pkg::ADDR_MASK);
   wire wr_urgent = i_wr && (i_addr == ucc_pkg::ADDR_URGENT);
   wire wr_ctl = i_wr && (i_addr == ucc_pkg::ADDR_CTRL);
   wire wr_brk = i_wr && (i_addr == ucc_pkg::ADDR_BRKCNT);
   wire hunt_cmd = wr_ctl && i_wdata[ucc_pkg::CTL_HUNT];
   wire tx_en = ctl_ff[ucc_pkg::CTL_TX_EN];
   wire cts_mon = ctl_ff[ucc_pkg::CTL_CTS_MON];
   wire [15:0] rd_mux;
   wire [15:0] status_word = {14'h0, state_ff != ucc_pkg::UCC_TX_IDLE, asleep_ff};
   assign rd_mux = (i_addr < ucc_pkg::ADDR_MASK) ? entry_ff[i_addr[3:1]] :
                   (i_addr == ucc_pkg::ADDR_MASK) ? mask_ff :
                   (i_addr == ucc_pkg::ADDR_REJ) ? rej_ff :
                   (i_addr == ucc_pkg::ADDR_URGENT) ? urgent_ff :
                   (i_addr == ucc_pkg::ADDR_CTRL) ? ctl_ff :
                   (i_addr == ucc_pkg::ADDR_BRKCNT) ? brk_cnt_ff :
                   (i_addr == ucc_pkg::ADDR_STATUS) ? status_word : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Control character scan: a valid prefix of entries, stopped by the first end flag
   logic [ucc_pkg::NUM_ENTRIES-1:0] hit;
   logic [ucc_pkg::NUM_ENTRIES-1:0] hit_rej;
   logic live;
   always_comb begin
      live = 1'b1;
      hit = '0;
      hit_rej = '0;
      for (int i = 0; i < ucc_pkg::NUM_ENTRIES; i++) begin
         if (entry_ff[i][ucc_pkg::BIT_END]) begin
            live = 1'b0; // [RQ3]
         end
         hit[i] = live && char_match(entry_ff[i], i_rx_char.data, mask_ff[7:0]); // [RQ1] [RQ2] [RQ6]
         hit_rej[i] = hit[i] && entry_ff[i][ucc_pkg::BIT_REJECT];
      end
   end
   // First matching entry decides the action
   logic first_rej;
   always_comb begin
      first_rej = 1'b0;
      for (int i = ucc_pkg::NUM_ENTRIES - 1; i >= 0; i--) begin
         if (hit[i]) begin
            first_rej = hit_rej[i];
         end
      end
   end
   wire any_hit = |hit;
   wire rx_ok = i_rx_valid && !asleep_ff && !i_rx_char.break_event;
   wire is_rej = rx_ok && any_hit && first_rej;
   wire is_acc = rx_ok && any_hit && !first_rej;

   // Wake-up: idle character time or address bit
   wire idle_done = (idle_cnt_ff == ucc_pkg::IDLE_BITS);
   wire wake = ctl_ff[ucc_pkg::CTL_WAKE_ADDR] ? (i_rx_valid && i_rx_char.addr_bit) : idle_done;

   ////////////////////////////////////////////////////////////////////////////////
   // Urgent transmit sequencing
   wire urgent_rdy = urgent_ff[ucc_pkg::BIT_READY];
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ucc_pkg::UCC_TX_IDLE: begin
            if (tx_en && urgent_rdy) begin
               nxt_state = ucc_pkg::UCC_TX_WAIT; // [RQ12]
            end
         end
         ucc_pkg::UCC_TX_WAIT: begin
            if (i_fifo_ready) begin
               nxt_state = ucc_pkg::UCC_TX_SEND; // [RQ13]
            end
         end
         ucc_pkg::UCC_TX_SEND: begin
            if (i_char_sent) begin
               nxt_state = ucc_pkg::UCC_TX_IDLE;
            end
         end
         default: nxt_state = ucc_pkg::UCC_TX_IDLE;
      endcase
   end
   wire sent_done = (state_ff == ucc_pkg::UCC_TX_SEND) && i_char_sent;
   wire cts_drop = cts_mon && cts_sync_ff && (state_ff == ucc_pkg::UCC_TX_SEND);

   assign o_rdata = rdata_ff;
   assign o_rx_store = store_ff;
   assign o_rx_close = close_ff;
   assign o_rx_drop = drop_ff;
   assign o_evt_ctrl_accept = acc_ff;
   assign o_evt_ctrl_reject = rej_evt_ff;
   assign o_evt_break = brk_evt_ff;
   assign o_evt_tx = tx_evt_ff;
   assign o_evt_cts = cts_evt_ff;
   assign o_rx_asleep = asleep_ff;
   assign o_tx_enable = tx_en;
   assign o_urgent_valid = (state_ff == ucc_pkg::UCC_TX_WAIT) && i_fifo_ready;
   // Buffer characters wait while the urgent one is pending
   assign o_hold_buffer = (state_ff != ucc_pkg::UCC_TX_IDLE); // [RQ13]
   assign o_urgent_char = '{data: urgent_ff[7:0], addr_bit: urgent_ff[ucc_pkg::BIT_ADDR]}; // [RQ20] [RQ21]

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk) begin
      cts_meta_ff <= i_cts_n;
      cts_sync_ff <= cts_meta_ff;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         for (int i = 0; i < ucc_pkg::NUM_ENTRIES; i++) begin
            entry_ff[i] <= ucc_pkg::ENTRY_RESET;
         end
         mask_ff <= ucc_pkg::MASK_RESET;
         ctl_ff <= ucc_pkg::CTL_RESET;
         rdata_ff <= 16'h0000;
      end else begin
         if (wr_entry) begin
            entry_ff[entry_idx] <= i_wdata;
         end
         if (wr_mask) begin
            mask_ff <= i_wdata;
         end
         if (wr_ctl) begin
            ctl_ff <= i_wdata & ~(16'h0001 << ucc_pkg::CTL_HUNT);
         end
         rdata_ff <= i_rd ? rd_mux : 16'h0000;
      end
   end

   // Receive side
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         rej_ff <= 16'h0000;
         asleep_ff <= 1'b0;
         idle_cnt_ff <= 4'h0;
         brk_cnt_ff <= 16'h0000;
         store_ff <= 1'b0;
         close_ff <= 1'b0;
         drop_ff <= 1'b0;
         acc_ff <= 1'b0;
         rej_evt_ff <= 1'b0;
         brk_evt_ff <= 1'b0;
      end else begin
         store_ff <= rx_ok && !is_rej; // [RQ4] [RQ5]
         close_ff <= is_acc || hunt_cmd; // [RQ4]
         drop_ff <= i_rx_valid && asleep_ff; // [RQ10]
         acc_ff <= is_acc; // [RQ4]
         rej_evt_ff <= is_rej; // [RQ5]
         if (is_rej) begin
            rej_ff <= {8'h00, i_rx_char.data}; // [RQ5] [RQ9]
         end
         brk_evt_ff <= 1'b0;
         if (asleep_ff && i_rx_valid && i_rx_char.break_event) begin
            brk_cnt_ff <= brk_cnt_ff + 16'h0001; // [RQ11]
            brk_evt_ff <= ctl_ff[ucc_pkg::CTL_BRK_IE]; // [RQ11]
         end else if (wr_brk) begin
            brk_cnt_ff <= i_wdata;
         end
         if (!asleep_ff || !i_line_idle || i_rx_valid) begin
            idle_cnt_ff <= 4'h0;
         end else if (i_bit_en && !idle_done) begin
            idle_cnt_ff <= idle_cnt_ff + 4'h1;
         end
         if (hunt_cmd) begin
            asleep_ff <= 1'b1; // [RQ10]
         end else if (asleep_ff && wake) begin
            asleep_ff <= 1'b0; // [RQ10]
         end
      end
   end

   // Transmit side
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state_ff <= ucc_pkg::UCC_TX_IDLE;
         urgent_ff <= 16'h0000;
         cts_lost_ff <= 1'b0;
         tx_evt_ff <= 1'b0;
         cts_evt_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         tx_evt_ff <= sent_done && urgent_ff[ucc_pkg::BIT_IRQ]; // [RQ17]
         cts_evt_ff <= sent_done && (cts_lost_ff || cts_drop); // [RQ18]
         if (state_ff == ucc_pkg::UCC_TX_IDLE) begin
            cts_lost_ff <= 1'b0;
         end else if (cts_drop) begin
            cts_lost_ff <= 1'b1;
         end
         if (sent_done) begin
            urgent_ff[ucc_pkg::BIT_READY] <= 1'b0; // [RQ16]
            urgent_ff[ucc_pkg::BIT_LOST_CTS] <= cts_lost_ff || cts_drop; // [RQ18]
         end else if (wr_urgent && (!urgent_rdy || state_ff == ucc_pkg::UCC_TX_IDLE)) begin
            urgent_ff <= i_wdata & ucc_pkg::URGENT_WMASK; // [RQ15] [RQ16]
         end
      end
   end
endmodule // ucc_ctrl_char_oos

`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the control character and urgent transmit block
// Assumes: Peer model drives the line side
// Notes: Table rows cover matching, hand tests cover sleep and urgent sends
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic i_ref_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [5:0] i_addr = 6'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic slow = 1'b0;
   logic [15:0] o_rdata, v;
   logic i_rx_valid, i_bit_en, i_line_idle, i_fifo_ready, i_char_sent, i_cts_n;
   ucc_pkg::ucc_rx_char_t i_rx_char;
   ucc_pkg::ucc_tx_char_t o_urgent_char, last_char;
   logic o_rx_store, o_rx_close, o_rx_drop, o_evt_ctrl_accept, o_evt_ctrl_reject, o_evt_break;
   logic o_evt_tx, o_evt_cts, o_rx_asleep, o_tx_enable, o_urgent_valid, o_hold_buffer;
   int num_errors = 0, checked = 0, cyc = 0, n_tx = 0, n_cts = 0, n_brk = 0;
   // Mask, char, expected {store, close, accept, reject}
   logic [27:0] rows [6] = '{28'hc0ff111, 28'hc0ff0ae, 28'hc0ff418, 28'hc0ff558, 28'hc0fe0be, 28'hc0fe101};
   always #50 i_ref_clk = ~i_ref_clk;
   ucc_ctrl_char_oos dut_u (.i_ref_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_rx_valid,
      .i_rx_char, .i_bit_en, .i_line_idle, .o_rx_store, .o_rx_close, .o_rx_drop, .o_evt_ctrl_accept,
      .o_evt_ctrl_reject, .o_evt_break, .o_evt_tx, .o_evt_cts, .o_rx_asleep, .o_tx_enable, .i_fifo_ready,
      .o_urgent_valid, .o_urgent_char, .o_hold_buffer, .i_char_sent, .i_cts_n);
   ucc_peer peer_u (.i_ref_clk, .i_urgent_valid(o_urgent_valid), .i_slow(slow), .o_rx_valid(i_rx_valid),
      .o_rx_char(i_rx_char), .o_bit_en(i_bit_en), .o_line_idle(i_line_idle), .o_fifo_ready(i_fifo_ready),
      .o_char_sent(i_char_sent), .o_cts_n(i_cts_n));
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (o_evt_tx === 1'b1) n_tx <= n_tx + 1;
      if (o_evt_cts === 1'b1) n_cts <= n_cts + 1;
      if (o_evt_break === 1'b1) n_brk <= n_brk + 1;
      if (o_urgent_valid === 1'b1) last_char <= o_urgent_char;
      if (cyc == 5000) begin
         num_errors++;
         give_verdict;
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   task automatic rx(input logic [7:0] d, input logic a, input logic [15:0] e);
      peer_u.send(d, a, 1'b0);
      #1 chk("rx_flags", e, {11'h000, o_rx_drop, o_rx_store, o_rx_close, o_evt_ctrl_accept, o_evt_ctrl_reject});
   endtask
   task automatic wait_tx(input int n);
      repeat (60) if (n_tx < n) @(posedge i_ref_clk);
      chk("tx_events", 16'(n), 16'(n_tx));
   endtask
   task automatic give_verdict;
      $display("Checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      rd(ucc_pkg::ADDR_ENTRY_BASE);
      chk("entry_reset", ucc_pkg::ENTRY_RESET, v);
      rd(ucc_pkg::ADDR_MASK);
      chk("mask_reset", ucc_pkg::MASK_RESET, v);
      rd(6'h1c);
      chk("unmapped", 16'h0000, v);
      wr(6'h00, 16'h4011);
      wr(6'h02, 16'h000a);
      wr(6'h04, 16'h8000);  // End flag hides the entry after it
      wr(6'h06, 16'h0041);
      foreach (rows[i]) begin
         wr(ucc_pkg::ADDR_MASK, rows[i][27:12]);  // Top mask bits kept set
         rx(rows[i][11:4], 1'b0, {12'h000, rows[i][3:0]});
         if (rows[i][0]) begin
            rd(ucc_pkg::ADDR_REJ);
            chk("holding", {8'h00, rows[i][11:4]}, v);
         end
      end
      for (int i = 0; i < 7; i++) begin
         wr(6'(2 * i), 16'h0060 + 16'(i));  // Full table, short chars with zero top bits
      end
      wr(6'h0e, 16'h4077);
      rx(8'h77, 1'b0, 16'h0001);
      wr(ucc_pkg::ADDR_CTRL, 16'h0014);  // Hunt, wake on idle, break event on
      #1 chk("hunt_close", 16'h0001, 16'(o_rx_close));
      repeat (3) @(posedge i_ref_clk);
      rx(8'h60, 1'b0, 16'h0010);
      peer_u.send(8'h00, 1'b0, 1'b1);
      repeat (2) @(posedge i_ref_clk);
      chk("break_events", 16'h0001, 16'(n_brk));
      rd(ucc_pkg::ADDR_BRKCNT);
      chk("break_count", 16'h0001, v);
      peer_u.idle(8);
      #1 chk("asleep_short_idle", 16'h0001, 16'(o_rx_asleep));
      peer_u.idle(4);
      #1 chk("awake_after_idle", 16'h0000, 16'(o_rx_asleep));
      wr(ucc_pkg::ADDR_CTRL, 16'h0006);  // Hunt, wake on address bit
      repeat (3) @(posedge i_ref_clk);
      rx(8'h55, 1'b0, 16'h0010);
      peer_u.send(8'h5a, 1'b1, 1'b0);
      repeat (2) @(posedge i_ref_clk);
      #1 chk("awake_after_addr", 16'h0000, 16'(o_rx_asleep));
      wr(ucc_pkg::ADDR_CTRL, 16'h0000);
      wr(ucc_pkg::ADDR_URGENT, 16'hf011);  // Top bits are don't care
      repeat (5) @(posedge i_ref_clk);
      chk("offer_tx_off", 16'h0000, 16'(o_urgent_valid));
      wr(ucc_pkg::ADDR_CTRL, 16'h0009);  // Transmit on, clear-to-send watched
      wait_tx(1);
      rd(ucc_pkg::ADDR_URGENT);
      chk("urgent_done", 16'h1011, v & 16'h3fff);
      chk("urgent_char", 16'h0022, 16'(last_char));
      slow <= 1'b1;
      wr(ucc_pkg::ADDR_URGENT, 16'h3122);  // Address bit set, ready clear before
      repeat (2) @(posedge i_ref_clk);
      #1 chk("hold_buffer", 16'h0001, 16'(o_hold_buffer));
      wait_tx(2);
      chk("cts_events", 16'h0001, 16'(n_cts));
      rd(ucc_pkg::ADDR_URGENT);
      chk("urgent_cts", 16'h1922, v & 16'h3fff);
      chk("urgent_addr_char", 16'h0045, 16'(last_char));
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire

// *** sim/ucc_chk_sva.sv ***
// Purpose: Port assertions for the control character and urgent transmit block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module ucc_chk (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_rx_valid,
   input wire logic i_fifo_ready,
   input wire logic i_char_sent,
   input wire logic o_rx_store,
   input wire logic o_rx_close,
   input wire logic o_rx_drop,
   input wire logic o_evt_ctrl_accept,
   input wire logic o_evt_ctrl_reject,
   input wire logic o_evt_break,
   input wire logic o_evt_tx,
   input wire logic o_evt_cts,
   input wire logic o_rx_asleep,
   input wire logic o_tx_enable,
   input wire logic o_urgent_valid,
   input wire logic o_hold_buffer
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   sequence s_taken;
      o_urgent_valid && i_fifo_ready;
   endsequence
   a_reject_not_stored: assert property (o_evt_ctrl_reject |-> !o_rx_store && !o_rx_close)
      else $error("rejected char stored");
   a_accept_closes: assert property (o_evt_ctrl_accept |-> o_rx_store && o_rx_close)
      else $error("accepted char not stored and closed");
   a_drop_silent: assert property (o_rx_drop |-> !o_rx_store && !o_evt_ctrl_accept && !o_evt_ctrl_reject)
      else $error("asleep char acted on");
   a_ctrl_needs_char: assert property (o_evt_ctrl_accept || o_evt_ctrl_reject |-> $past(i_rx_valid))
      else $error("control event without char");
   a_tx_evt_cause: assert property (o_evt_tx |-> $past(i_char_sent))
      else $error("tx event without sent char");
   a_cts_evt_cause: assert property (o_evt_cts |-> $past(i_char_sent))
      else $error("cts event outside send end");
   a_urgent_gated: assert property (s_taken |-> o_tx_enable && o_hold_buffer)
      else $error("urgent offer while disabled or unheld");
   a_break_asleep: assert property (o_evt_break |-> $past(o_rx_asleep))
      else $error("break event while awake");
endmodule // ucc_chk
bind ucc_ctrl_char_oos ucc_chk chk_u (.i_ref_clk, .i_reset, .i_rx_valid, .i_fifo_ready, .i_char_sent,
   .o_rx_store, .o_rx_close, .o_rx_drop, .o_evt_ctrl_accept, .o_evt_ctrl_reject, .o_evt_break,
   .o_evt_tx, .o_evt_cts, .o_rx_asleep, .o_tx_enable, .o_urgent_valid, .o_hold_buffer);
`default_nettype wire

// *** sim/ucc_peer.sv ***
// Purpose: Line-side station model: receive chars in, urgent chars out
// Assumes: Slow mode stretches sending and drops clear-to-send
// Notes: Released char bus shows the inverse of the last char
`timescale 1ns/1ps
`default_nettype none
module ucc_peer (
   input wire logic i_ref_clk,
   input wire logic i_urgent_valid,
   input wire logic i_slow,
   output logic o_rx_valid,
   output ucc_pkg::ucc_rx_char_t o_rx_char,
   output logic o_bit_en,
   output logic o_line_idle,
   output logic o_fifo_ready,
   output logic o_char_sent,
   output logic o_cts_n
);
   logic [3:0] cnt_ff = 4'h0;
   logic busy_ff = 1'b0;
   initial begin
      o_rx_valid = 1'b0;
      o_rx_char = '0;
      o_bit_en = 1'b0;
      o_line_idle = 1'b0;
      o_fifo_ready = 1'b1;
      o_char_sent = 1'b0;
      o_cts_n = 1'b0;
   end
   always @(posedge i_ref_clk) begin
      o_char_sent <= 1'b0;
      if (busy_ff && cnt_ff == 4'h0) begin
         busy_ff <= 1'b0;
         o_char_sent <= 1'b1;
         o_fifo_ready <= 1'b1;
         o_cts_n <= 1'b0;
      end else if (busy_ff) begin
         cnt_ff <= cnt_ff - 4'h1;
         o_cts_n <= i_slow;
      end else if (i_urgent_valid && o_fifo_ready) begin
         busy_ff <= 1'b1;
         cnt_ff <= i_slow ? 4'h9 : 4'h2;
         o_fifo_ready <= 1'b0;
      end
   end
   task automatic send(input logic [7:0] d, input logic a, input logic b);
      @(posedge i_ref_clk);
      o_line_idle <= 1'b0;
      o_rx_valid <= 1'b1;
      o_rx_char <= {d, a, b};
      @(posedge i_ref_clk);
      o_rx_valid <= 1'b0;
      o_rx_char <= ~{d, a, b};
   endtask
   task automatic idle(input int n);
      @(posedge i_ref_clk);
      o_line_idle <= 1'b1;
      repeat (n) begin
         @(posedge i_ref_clk);
         o_bit_en <= 1'b1;
         @(posedge i_ref_clk);
         o_bit_en <= 1'b0;
      end
   endtask
endmodule // ucc_peer
`default_nettype wire
